// ===== tcm_monitor_sink.sv
// Purpose: non-intrusive sink monitor for a vc-4 tandem connection
// Assumes: management inputs are on core_clk, the path stream on path_clk
// Notes: the passing vc-4 is never altered; every byte feeds parity, overhead is decoded
//
// What this block does
// - even parity per bit over previous frame, compared with b3 of this frame
// - flag near errored block when |bip errors minus incoming count| is one or more
// - any parity mismatch declares an outgoing errored block for the frame
// - incoming error code taken from bits 1-4 exactly as received
// - codes 0-8 mean that many errors, codes 9 upward mean zero
// - trace built from multiframe positions 9-72 and presented to management
// - only the first trace mode is supported, no legacy mode
// - bit 5 is counted as a far-end block error
// - multiframe position 73 carries remote defect, one means defect
// - bit 6 is counted as a far-end outgoing block error
// - multiframe position 74 carries outgoing defect, one means defect
// - alignment found by searching bits 7-8 for the 16-bit pattern
// - once aligned, pattern rechecked at presumed start every multiframe
// - two consecutive errored alignment words enter the lost state
// - one clean alignment word returns to the locked state
// - tandem loss defect follows the lost state of multiframe alignment
// - unequipped set after five all-zero frames, cleared after five others
// - reports gated by monitoring enable; server fail also needs its enable
// - tandem loss report needs enable, tandem loss, no unequipped
// - trace mismatch report needs enable, mismatch, no unequipped, no tandem loss
// - degrade report needs enable, degrade, no mismatch, no tandem loss
// - remote report needs enable, defect, its enable, none of three defects
// - outgoing report needs enable, defect, its enable, none of three defects
// - per second produce defect-second flags and summed block error counts
`default_nettype none
module tcm_monitor_sink (
	// clocks and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic path_clk,
	// vc-4 path stream
	input wire logic [7:0] path_data,
	input wire logic path_frame_start,
	input wire logic incoming_server_fail,
	// management controls
	input wire logic monitoring_enabled,
	input wire logic server_fail_report_enable,
	input wire logic remote_defect_report_enable,
	input wire logic outgoing_defect_report_enable,
	input wire logic trace_check_disable,
	input wire logic [127:0] expected_trace,
	input wire logic [15:0] degrade_threshold,
	input wire logic equipment_defect,
	input wire logic one_second_tick,
	// consequent actions
	output logic trail_fail_action,
	output logic outgoing_defect_action,
	// correlated reports
	output logic unequipped_report,
	output logic tandem_loss_report,
	output logic trace_mismatch_report,
	output logic degrade_report,
	output logic server_fail_report,
	output logic remote_defect_report,
	output logic outgoing_defect_report,
	// trace
	output logic [127:0] accepted_trace,
	// per-second primitives
	output logic near_defect_second,
	output logic far_defect_second,
	output logic outgoing_near_defect_second,
	output logic outgoing_far_defect_second,
	output logic [15:0] near_block_error_count,
	output logic [15:0] far_block_error_count,
	output logic [15:0] outgoing_near_error_count,
	output logic [15:0] outgoing_far_error_count
);
	// ************************************************
	// path side and domain crossing
	// ************************************************
	tcm_frame_if fr ();
	logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
	logic ssf_s1_reg, ssf_s2_reg;
	logic ev;

	tcm_link_rx u_rx (
		.path_clk(path_clk),
		.rst(rst),
		.path_data(path_data),
		.path_frame_start(path_frame_start),
		.fr(fr.rx)
	);

	// the toggle is synchronised; n1 and bip_err are held a whole frame,
	// so they are stable long before the synchronised edge arrives
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			tog_s3_reg <= 1'b0;
			ssf_s1_reg <= 1'b0;
			ssf_s2_reg <= 1'b0;
		end else begin
			tog_s1_reg <= fr.toggle;
			tog_s2_reg <= tog_s1_reg;
			tog_s3_reg <= tog_s2_reg;
			ssf_s1_reg <= incoming_server_fail;
			ssf_s2_reg <= ssf_s1_reg;
		end
	end

	assign ev = tog_s2_reg ^ tog_s3_reg;

	// ************************************************
	// per-frame error decoding
	// ************************************************
	logic [3:0] iec_code;
	logic [3:0] iec_errs;
	logic [3:0] err_diff;
	logic near_blk, out_near_blk, far_blk, far_out_blk;

	assign iec_code = fr.n1[tcm_pkg::IEC_HI:tcm_pkg::IEC_LO];
	// codes above eight carry other meanings and count as no errors
	assign iec_errs = (iec_code <= tcm_pkg::IEC_MAX) ? iec_code : 4'h0;
	assign err_diff = (fr.bip_err >= iec_errs) ? fr.bip_err - iec_errs
		: iec_errs - fr.bip_err;
	assign near_blk = ev && (err_diff != 4'h0);
	assign out_near_blk = ev && (fr.bip_err != 4'h0);
	assign far_blk = ev && fr.n1[tcm_pkg::REI_BIT];
	assign far_out_blk = ev && fr.n1[tcm_pkg::OEI_BIT];

	// ************************************************
	// multiframe and carried indications
	// ************************************************
	logic locked;
	logic [6:0] cur_pos;
	logic ltc;

	tcm_mf_align u_mf (
		.core_clk(core_clk),
		.rst(rst),
		.frame_ev(ev),
		.mf_bits(fr.n1[tcm_pkg::MF7_BIT:tcm_pkg::MF8_BIT]),
		.locked(locked),
		.cur_pos(cur_pos)
	);

	assign ltc = !locked;

	logic rdi_reg, odi_reg;

	// remote indications only trusted while the multiframe is locked
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdi_reg <= 1'b0;
			odi_reg <= 1'b0;
		end else if (ev && locked) begin
			if (cur_pos == tcm_pkg::RDI_POS) begin
				rdi_reg <= fr.n1[tcm_pkg::MF8_BIT];
			end
			if (cur_pos == tcm_pkg::ODI_POS) begin
				odi_reg <= fr.n1[tcm_pkg::MF7_BIT];
			end
		end
	end

	// ************************************************
	// trace identifier
	// ************************************************
	logic [127:0] rx_trace_reg, prev_trace_reg;
	logic [127:0] rx_trace_next;
	logic tim_reg;

	assign rx_trace_next = {rx_trace_reg[125:0], fr.n1[tcm_pkg::MF7_BIT:tcm_pkg::MF8_BIT]};

	// single mode only: a trace is accepted once two multiframes agree,
	// which filters a lone corrupted multiframe at the cost of latency
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_trace_reg <= '0;
			prev_trace_reg <= '0;
			accepted_trace <= '0;
		end else if (ev && locked && cur_pos >= tcm_pkg::TI_FIRST
			&& cur_pos <= tcm_pkg::TI_LAST) begin
			rx_trace_reg <= rx_trace_next;
			if (cur_pos == tcm_pkg::TI_LAST) begin
				prev_trace_reg <= rx_trace_next;
				if (rx_trace_next == prev_trace_reg) begin
					accepted_trace <= rx_trace_next;
				end
			end
		end
	end

	// mismatch is suppressed under server fail and by the disable control
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tim_reg <= 1'b0;
		end else begin
			tim_reg <= !trace_check_disable && !ssf_s2_reg && (accepted_trace != expected_trace);
		end
	end

	// ************************************************
	// unequipped detection
	// ************************************************
	logic uneq_reg;
	logic [2:0] uneq_cnt_reg;
	logic uneq_seen;

	assign uneq_seen = (fr.n1 == tcm_pkg::UNEQ_CODE);

	// count frames that disagree with the present state; five in a row flip it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			uneq_reg <= 1'b0;
			uneq_cnt_reg <= 3'h0;
		end else if (ev) begin
			if (uneq_seen != uneq_reg) begin
				if (uneq_cnt_reg == tcm_pkg::UNEQ_PERSIST - 3'h1) begin
					uneq_reg <= uneq_seen;
					uneq_cnt_reg <= 3'h0;
				end else begin
					uneq_cnt_reg <= uneq_cnt_reg + 3'h1;
				end
			end else begin
				uneq_cnt_reg <= 3'h0;
			end
		end
	end

	// ************************************************
	// correlation and actions
	// ************************************************
	logic deg_reg;
	logic fail_now, odi_now;

	assign fail_now = ssf_s2_reg || uneq_reg || tim_reg || ltc;
	assign odi_now = ssf_s2_reg || uneq_reg || tim_reg || ltc;

	// every report is gated by the monitoring enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trail_fail_action <= 1'b0;
			outgoing_defect_action <= 1'b0;
			unequipped_report <= 1'b0;
			tandem_loss_report <= 1'b0;
			trace_mismatch_report <= 1'b0;
			degrade_report <= 1'b0;
			server_fail_report <= 1'b0;
			remote_defect_report <= 1'b0;
			outgoing_defect_report <= 1'b0;
		end else begin
			trail_fail_action <= fail_now;
			outgoing_defect_action <= odi_now;
			unequipped_report <= monitoring_enabled && uneq_reg;
			server_fail_report <= monitoring_enabled && ssf_s2_reg
				&& server_fail_report_enable;
			tandem_loss_report <= monitoring_enabled && !uneq_reg && ltc;
			trace_mismatch_report <= monitoring_enabled && !uneq_reg && !ltc
				&& tim_reg;
			degrade_report <= monitoring_enabled && !tim_reg && !ltc && deg_reg;
			remote_defect_report <= monitoring_enabled && !uneq_reg && !tim_reg && !ltc
				&& rdi_reg && remote_defect_report_enable;
			outgoing_defect_report <= monitoring_enabled && !uneq_reg && !tim_reg && !ltc
				&& odi_reg && outgoing_defect_report_enable;
		end
	end

	// ************************************************
	// per-second performance primitives
	// ************************************************
	logic [3:0] pm_inc;
	logic [3:0] ds_cond;
	logic [15:0] cnt_acc_reg [tcm_pkg::NUM_PM];
	logic [15:0] cnt_out_reg [tcm_pkg::NUM_PM];
	logic [3:0] ds_acc_reg, ds_out_reg;

	assign pm_inc = {far_out_blk, out_near_blk, far_blk, near_blk};
	assign ds_cond = {odi_reg, odi_now || equipment_defect, rdi_reg,
		fail_now || equipment_defect};

	// an event in the tick cycle opens the new second instead of being lost
	genvar gi;
	generate
		for (gi = 0; gi < tcm_pkg::NUM_PM; gi++) begin : g_pm
			always_ff @(posedge core_clk) begin
				if (rst) begin
					cnt_acc_reg[gi] <= 16'h0000;
					cnt_out_reg[gi] <= 16'h0000;
					ds_acc_reg[gi] <= 1'b0;
					ds_out_reg[gi] <= 1'b0;
				end else if (one_second_tick) begin
					cnt_out_reg[gi] <= cnt_acc_reg[gi];
					cnt_acc_reg[gi] <= {15'h0000, pm_inc[gi]};
					ds_out_reg[gi] <= ds_acc_reg[gi] || ds_cond[gi];
					ds_acc_reg[gi] <= ds_cond[gi];
				end else begin
					if (pm_inc[gi] && !(&cnt_acc_reg[gi])) begin
						cnt_acc_reg[gi] <= cnt_acc_reg[gi] + 16'h0001;
					end
					ds_acc_reg[gi] <= ds_acc_reg[gi] || ds_cond[gi];
				end
			end
		end
	endgenerate

	// degrade judged per second against the near-end errored block count
	always_ff @(posedge core_clk) begin
		if (rst) begin
			deg_reg <= 1'b0;
		end else if (one_second_tick) begin
			deg_reg <= cnt_acc_reg[0] > degrade_threshold;
		end
	end

	assign near_block_error_count = cnt_out_reg[0];
	assign far_block_error_count = cnt_out_reg[1];
	assign outgoing_near_error_count = cnt_out_reg[2];
	assign outgoing_far_error_count = cnt_out_reg[3];
	assign near_defect_second = ds_out_reg[0];
	assign far_defect_second = ds_out_reg[1];
	assign outgoing_near_defect_second = ds_out_reg[2];
	assign outgoing_far_defect_second = ds_out_reg[3];

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_iec_high;
		ev && iec_code > 4'h8 && fr.bip_err == 4'h0 |-> !near_blk;
	endproperty
	a_iec_high: assert property (p_iec_high) else $error("high iec code counted errors");
	property p_out_blk;
		ev && fr.bip_err != 4'h0 && !one_second_tick && cnt_acc_reg[2] < 16'h00ff
			|=> cnt_acc_reg[2] == 16'($past(cnt_acc_reg[2]) + 16'h0001);
	endproperty
	a_out_blk: assert property (p_out_blk) else $error("parity error not counted");
	property p_uneq_set;
		$rose(uneq_reg) |-> $past(uneq_cnt_reg) == 3'h4 && fr.n1 == 8'h00;
	endproperty
	a_uneq_set: assert property (p_uneq_set) else $error("unequipped set too early");
	property p_mon_off;
		!monitoring_enabled |=> !unequipped_report && !server_fail_report && !degrade_report;
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("report without monitoring");
	property p_ltc_rep;
		(monitoring_enabled && ltc && !uneq_reg) [*2] |=> tandem_loss_report;
	endproperty
	a_ltc_rep: assert property (p_ltc_rep) else $error("tandem loss not reported");
	property p_tim_rep;
		uneq_reg || ltc |=> !trace_mismatch_report;
	endproperty
	a_tim_rep: assert property (p_tim_rep) else $error("mismatch report not masked");
	property p_deg_rep;
		tim_reg || ltc |=> !degrade_report;
	endproperty
	a_deg_rep: assert property (p_deg_rep) else $error("degrade report not masked");
	property p_rdi_rep;
		!remote_defect_report_enable || uneq_reg |=> !remote_defect_report;
	endproperty
	a_rdi_rep: assert property (p_rdi_rep) else $error("remote report not masked");
	property p_odi_rep;
		!outgoing_defect_report_enable || tim_reg |=> !outgoing_defect_report;
	endproperty
	a_odi_rep: assert property (p_odi_rep) else $error("outgoing report not masked");
	property p_tick;
		one_second_tick |=> near_block_error_count == $past(cnt_acc_reg[0])
			&& far_block_error_count == $past(cnt_acc_reg[1]);
	endproperty
	a_tick: assert property (p_tick) else $error("counts not latched at tick");
endmodule
`default_nettype wire

// ===== tcm_pkg.sv
// Purpose: shared constants and types of the tandem connection monitor sink
// Assumes: vc-4 delivered byte by byte, one byte per path clock, row by row
// Notes: byte indices count from the j1 byte, which carries the frame start
`default_nettype none
package tcm_pkg;
	// ************************************************
	// frame layout
	// ************************************************
	localparam logic [11:0] B3_IDX = 12'h105; // row 1, first column
	localparam logic [11:0] N1_IDX = 12'h828; // row 8, first column
	// tandem overhead byte fields, bit 1 is the msb
	localparam int IEC_HI = 7;
	localparam int IEC_LO = 4;
	localparam int REI_BIT = 3;
	localparam int OEI_BIT = 2;
	localparam int MF7_BIT = 1;
	localparam int MF8_BIT = 0;
	localparam logic [3:0] IEC_MAX = 4'h8;
	localparam logic [7:0] UNEQ_CODE = 8'h00;
	localparam logic [2:0] UNEQ_PERSIST = 3'h5;
	// ************************************************
	// multiframe layout
	// ************************************************
	localparam logic [15:0] MFAS = 16'hfffe;
	localparam logic [6:0] MF_LEN = 7'h4c;
	localparam logic [6:0] MF_FAS_END = 7'h08;
	localparam logic [6:0] TI_FIRST = 7'h09;
	localparam logic [6:0] TI_LAST = 7'h48;
	localparam logic [6:0] RDI_POS = 7'h49;
	localparam logic [6:0] ODI_POS = 7'h4a;
	localparam int TI_W = 128;
	localparam int CNT_W = 16;
	localparam int NUM_PM = 4;
	typedef enum logic [0:0] {
		multiframe_lost_state = 1'b0,
		multiframe_locked_state = 1'b1
	} tcm_mf_state_t;
endpackage
`default_nettype wire

// ===== tcm_frame_if.sv
// Purpose: per-frame overhead handed from the path domain to the core domain
// Assumes: data is written with the toggle and then held for a whole frame
// Notes: the toggle is the only bit the core side synchronises
`default_nettype none
interface tcm_frame_if;
	logic toggle;
	logic [7:0] n1;
	logic [3:0] bip_err;
	modport rx (output toggle, output n1, output bip_err);
	modport core (input toggle, input n1, input bip_err);
endinterface
`default_nettype wire

// ===== tcm_link_rx.sv
// Purpose: path-side parity check and overhead capture for each vc-4 frame
// Assumes: one byte per path_clk edge, frame start marks the j1 byte
// Notes: nothing is reported until one full frame has been seen
`default_nettype none
module tcm_link_rx (
	// clocks and reset
	input wire logic path_clk,
	input wire logic rst,
	// path stream
	input wire logic [7:0] path_data,
	input wire logic path_frame_start,
	// frame event toward core
	tcm_frame_if.rx fr
);
	logic rst_s1_reg, rst_s2_reg;
	logic [11:0] idx_reg;
	logic [11:0] cur_idx;
	logic [7:0] acc_reg, prev_bip_reg;
	logic [3:0] mism_reg;
	logic started_reg, prev_ok_reg;

	// core reset brought into the path domain
	always_ff @(posedge path_clk) begin
		rst_s1_reg <= rst;
		rst_s2_reg <= rst_s1_reg;
	end

	assign cur_idx = path_frame_start ? 12'h000 : idx_reg;

	// byte position and running parity of every byte in the frame
	always_ff @(posedge path_clk) begin
		if (rst_s2_reg) begin
			idx_reg <= 12'h000;
			acc_reg <= 8'h00;
			prev_bip_reg <= 8'h00;
			started_reg <= 1'b0;
			prev_ok_reg <= 1'b0;
		end else begin
			idx_reg <= cur_idx + 12'h001;
			if (path_frame_start) begin
				acc_reg <= path_data;
				prev_bip_reg <= acc_reg;
				started_reg <= 1'b1;
				prev_ok_reg <= started_reg;
			end else begin
				acc_reg <= acc_reg ^ path_data;
			end
		end
	end

	// compare against b3 of this frame, hand over at the overhead byte
	always_ff @(posedge path_clk) begin
		if (rst_s2_reg) begin
			mism_reg <= 4'h0;
			fr.toggle <= 1'b0;
			fr.n1 <= 8'h00;
			fr.bip_err <= 4'h0;
		end else begin
			if (cur_idx == tcm_pkg::B3_IDX) begin
				mism_reg <= 4'($countones(prev_bip_reg ^ path_data));
			end
			if (cur_idx == tcm_pkg::N1_IDX && prev_ok_reg) begin
				fr.n1 <= path_data;
				fr.bip_err <= mism_reg;
				fr.toggle <= ~fr.toggle;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tcm_mf_align.sv
// Purpose: multiframe alignment on bits 7 and 8 of the tandem overhead byte
// Assumes: frame_ev pulses once per frame with mf_bits valid
// Notes: cur_pos is the position of the frame being presented now
`default_nettype none
module tcm_mf_align (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// per-frame input
	input wire logic frame_ev,
	input wire logic [1:0] mf_bits,
	// alignment state
	output logic locked,
	output logic [6:0] cur_pos
);
	tcm_pkg::tcm_mf_state_t state_reg;
	logic [15:0] sh_reg;
	logic [15:0] sh_next;
	logic [6:0] pos_reg;
	logic err_reg;
	logic fas_hit;

	assign sh_next = {sh_reg[13:0], mf_bits};
	assign fas_hit = (sh_next == tcm_pkg::MFAS);
	assign cur_pos = (pos_reg == tcm_pkg::MF_LEN) ? 7'h01 : pos_reg + 7'h01;
	assign locked = (state_reg == tcm_pkg::multiframe_locked_state);

	// search while lost, check the presumed word once per multiframe when locked
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= tcm_pkg::multiframe_lost_state;
			sh_reg <= 16'h0000;
			pos_reg <= 7'h01;
			err_reg <= 1'b0;
		end else if (frame_ev) begin
			sh_reg <= sh_next;
			pos_reg <= cur_pos;
			case (state_reg)
				tcm_pkg::multiframe_lost_state: begin
					if (fas_hit) begin
						state_reg <= tcm_pkg::multiframe_locked_state;
						pos_reg <= tcm_pkg::MF_FAS_END;
						err_reg <= 1'b0;
					end
				end
				tcm_pkg::multiframe_locked_state: begin
					if (cur_pos == tcm_pkg::MF_FAS_END) begin
						if (fas_hit) begin
							err_reg <= 1'b0;
						end else if (err_reg) begin
							state_reg <= tcm_pkg::multiframe_lost_state;
							err_reg <= 1'b0;
						end else begin
							err_reg <= 1'b1;
						end
					end
				end
				default: state_reg <= tcm_pkg::multiframe_lost_state;
			endcase
		end
	end

	sequence s_fas_bad;
		frame_ev && locked && cur_pos == 7'h08 && !fas_hit;
	endsequence
	property p_oom;
		@(posedge core_clk) disable iff (rst) s_fas_bad ##0 err_reg |=> !locked;
	endproperty
	a_oom: assert property (p_oom) else $error("two errored fas words did not unlock");
	property p_relock;
		@(posedge core_clk) disable iff (rst)
		frame_ev && !locked && fas_hit |=> locked && pos_reg == 7'h08;
	endproperty
	a_relock: assert property (p_relock) else $error("clean fas word did not lock");
endmodule
`default_nettype wire

// ===== tcm_vc4_src.sv
// Purpose: vc-4 byte stream source feeding the monitor sink
// Assumes: path clock runs free, frames of 2349 bytes
// Notes: b3 carries previous frame parity xor an error mask
`default_nettype none
module tcm_vc4_src (
	// clock and reset
	input wire logic path_clk,
	input wire logic rst,
	// per-frame settings, latched at frame start
	input wire logic [7:0] flip,
	input wire logic [3:0] iec,
	input wire logic rei,
	input wire logic oei,
	input wire logic mf_on,
	// stream
	output logic [7:0] path_data,
	output logic path_frame_start,
	output logic [7:0] frame_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************
	// byte generator
	// ************************************************
	logic [11:0] idx;
	logic [7:0] acc, par, b, fl;
	logic [5:0] nq;
	logic [6:0] pos;
	logic [1:0] mf;
	// launched on the falling edge so the sink samples settled bytes
	always @(negedge path_clk) begin
		if (rst) begin
			idx = 12'h000;
			acc = 8'h00;
			pos = 7'h00;
			frame_cnt <= 8'h00;
			path_frame_start <= 1'h0;
		end else begin
			if (idx == 12'h000) begin
				par = acc;
				acc = 8'h00;
				fl = flip;
				nq = {iec, rei, oei};
				pos = !mf_on ? 7'h00 : (pos == tcm_pkg::MF_LEN ? 7'h01 : pos + 7'h01);
				frame_cnt <= frame_cnt + 8'h01;
			end
			// alignment word bits only at positions 1 to 8, zeros elsewhere
			mf = (pos == 7'h00 || pos > 7'h08) ? 2'h0 : (pos == 7'h08 ? 2'h2 : 2'h3);
			b = idx[7:0];
			if (idx == tcm_pkg::B3_IDX)
				b = par ^ fl;
			if (idx == tcm_pkg::N1_IDX)
				b = {nq, mf};
			acc = acc ^ b;
			path_data <= b;
			path_frame_start <= (idx == 12'h000);
			idx = (idx == 12'h92c) ? 12'h000 : idx + 12'h001;
		end
	end
endmodule
`default_nettype wire

// ===== tcm_monitor_sink_test.sv
// Purpose: self-checking bench of the tandem monitor sink
// Assumes: frames come from the stream source model
// Notes: a multiframe is too long for a full cycle, so only lock is seen
`default_nettype none
module tcm_monitor_sink_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************
	// stimulus and wiring
	// ************************************************
	logic core_clk = 1'h0;
	logic path_clk = 1'h0;
	logic rst = 1'h1;
	logic incoming_server_fail = 1'h0;
	logic monitoring_enabled = 1'h1;
	logic server_fail_report_enable = 1'h0;
	logic equipment_defect = 1'h0;
	logic one_second_tick = 1'h0;
	logic mf_on = 1'h0;
	logic rei = 1'h0;
	logic oei = 1'h0;
	logic [7:0] flip = 8'h00;
	logic [3:0] iec = 4'h0;
	logic trace_check_disable = 1'h0;
	// differs from the all-zero trace the source sends, so a mismatch is seen
	logic [127:0] expected_trace = 128'h1;
	logic [7:0] path_data, frame_cnt;
	logic path_frame_start, trail_fail_action, unequipped_report, tandem_loss_report;
	logic trace_mismatch_report, server_fail_report, near_defect_second;
	logic outgoing_near_defect_second;
	logic outgoing_defect_action, degrade_report, far_defect_second, outgoing_far_defect_second;
	logic [15:0] near_block_error_count, far_block_error_count;
	logic [15:0] outgoing_near_error_count, outgoing_far_error_count;
	int error_cnt = 0;
	int check_count = 0;
	// unrelated clocks, 100 ns core and 64 ns path
	always #50 core_clk = ~core_clk;
	always #32 path_clk = ~path_clk;
	tcm_vc4_src i_src (.path_clk, .rst, .flip, .iec, .rei, .oei, .mf_on, .path_data,
		.path_frame_start, .frame_cnt);
	tcm_monitor_sink i_dut (
		.core_clk, .rst, .path_clk, .path_data, .path_frame_start, .incoming_server_fail,
		.monitoring_enabled, .server_fail_report_enable, .remote_defect_report_enable(1'h1),
		.outgoing_defect_report_enable(1'h1), .trace_check_disable,
		.expected_trace, .degrade_threshold(16'h0001), .equipment_defect,
		.one_second_tick, .trail_fail_action, .outgoing_defect_action, .unequipped_report,
		.tandem_loss_report, .trace_mismatch_report, .degrade_report, .server_fail_report,
		.remote_defect_report(), .outgoing_defect_report(), .accepted_trace(),
		.near_defect_second, .far_defect_second, .outgoing_near_defect_second,
		.outgoing_far_defect_second, .near_block_error_count, .far_block_error_count,
		.outgoing_near_error_count, .outgoing_far_error_count);
	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// set next frame's overhead, then wait until that frame starts
	task automatic frame(input logic [7:0] f, input logic [3:0] c, input logic r, input logic o);
		logic [7:0] n;
		int k;
		n = frame_cnt;
		k = 0;
		flip = f;
		iec = c;
		rei = r;
		oei = o;
		while (frame_cnt == n && k < 2000) begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 2000) begin
			error_cnt++;
			$display("wrong value at %0t: frame stalled", $time);
			tally_and_finish();
		end
	endtask
	// one-cycle tick; outputs are settled one edge later
	task automatic tick;
		@(negedge core_clk);
		one_second_tick = 1'h1;
		@(negedge core_clk);
		one_second_tick = 1'h0;
		@(negedge core_clk);
	endtask
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		repeat (4) @(negedge core_clk);
		chk(16'({trail_fail_action, unequipped_report, tandem_loss_report}), 16'h0000);
		rst = 1'h0;
		repeat (4) @(negedge core_clk);
		chk(16'(tandem_loss_report), 16'h0001);
		repeat (8) frame(8'h00, 4'h0, 1'h0, 1'h0);
		chk(16'(unequipped_report), 16'h0001);
		chk(16'(tandem_loss_report), 16'h0000);
		chk(16'(trace_mismatch_report), 16'h0000);
		monitoring_enabled = 1'h0;
		repeat (3) @(negedge core_clk);
		chk(16'({unequipped_report, tandem_loss_report}), 16'h0000);
		monitoring_enabled = 1'h1;
		mf_on = 1'h1;
		repeat (9) frame(8'h00, 4'h9, 1'h0, 1'h0);
		repeat (5) @(negedge core_clk);
		chk(16'(tandem_loss_report), 16'h0000);
		chk(16'(unequipped_report), 16'h0000);
		chk(16'(trace_mismatch_report), 16'h0001);
		// the disable must mask the mismatch within three cycles
		trace_check_disable = 1'h1;
		repeat (3) @(negedge core_clk);
		chk(16'(trace_mismatch_report), 16'h0000);
		expected_trace = 128'h0;
		trace_check_disable = 1'h0;
		tick();
		frame(8'h03, 4'h2, 1'h1, 1'h0);
		frame(8'h01, 4'h8, 1'h0, 1'h1);
		frame(8'h00, 4'h1, 1'h0, 1'h0);
		frame(8'h00, 4'h9, 1'h0, 1'h0);
		frame(8'h00, 4'h9, 1'h0, 1'h0);
		tick();
		chk(near_block_error_count, 16'h0002);
		chk(outgoing_near_error_count, 16'h0002);
		chk(far_block_error_count, 16'h0001);
		chk(outgoing_far_error_count, 16'h0001);
		chk(16'(near_defect_second), 16'h0000);
		// two near errored blocks exceed the threshold of one
		chk(16'(degrade_report), 16'h0001);
		equipment_defect = 1'h1;
		repeat (3) @(negedge core_clk);
		equipment_defect = 1'h0;
		tick();
		chk(16'({near_defect_second, outgoing_near_defect_second}), 16'h0003);
		chk(16'({far_defect_second, outgoing_far_defect_second, degrade_report}), 16'h0000);
		chk(near_block_error_count, 16'h0000);
		server_fail_report_enable = 1'h1;
		incoming_server_fail = 1'h1;
		repeat (5) @(negedge core_clk);
		chk(16'({server_fail_report, trail_fail_action, outgoing_defect_action}), 16'h0007);
		server_fail_report_enable = 1'h0;
		repeat (3) @(negedge core_clk);
		chk(16'(server_fail_report), 16'h0000);
		incoming_server_fail = 1'h0;
		tally_and_finish();
	end
endmodule
`default_nettype wire
